/* core/uart_baud_rate_generator.sv */
// apb-attached baud rate generator producing the serial bit clock tick
// Functional notes
// - high divisor byte register holds bits 15:8
// - divisor n is high byte concatenated low
// - narrow mode leaves the high byte out of the divisor
// - writing high byte restarts the counter
// - writing low byte restarts the counter
// - async narrow normal speed: fosc/(64(n+1))
// - async wide normal speed: fosc/(16(n+1))
// - synchronous mode: fosc/(4(n+1)) always
`timescale 1ns/10ps
module uart_baud_rate_generator
    import rate_gen_pkg::*;
(
    input  wire logic        clk_i,      // system clock, 125 MHz
    input  wire logic        srst_i,     // synchronous reset, active high
    input  wire logic        psel_i,     // apb select
    input  wire logic        penable_i,  // apb access phase
    input  wire logic        pwrite_i,   // apb direction
    input  wire logic [11:0] paddr_i,    // apb byte address
    input  wire logic [31:0] pwdata_i,   // apb write data
    output logic      [31:0] prdata_o,   // apb read data
    output logic             pready_o,   // apb ready, always one
    output logic             pslverr_o,  // apb error on unmapped address
    output logic             bit_tick_o  // one-cycle bit clock pulse
);

    // register state
    logic [7:0]  div_low_ff;      // divisor_low_byte
    logic [7:0]  div_high_ff;     // divisor_high_byte
    logic [7:0]  tx_status_ff;    // transmit_status_control
    logic [7:0]  baud_ctrl_ff;    // baud_control
    logic [7:0]  nxt_div_low;
    logic [7:0]  nxt_div_high;
    logic [7:0]  nxt_tx_status;
    logic [7:0]  nxt_baud_ctrl;
    // read data state, captured in the setup cycle
    logic [31:0] prdata_ff;       // read word held through access
    logic [31:0] nxt_prdata;      // next read word
    logic [31:0] rd_word;         // selected register word
    // counter state
    logic [5:0]  pre_ff;          // prescale counter
    logic [15:0] cnt_ff;          // divisor counter
    logic        tick_ff;         // registered tick
    logic [15:0] ticks_ff;        // count of ticks, read back
    logic [5:0]  nxt_pre;
    logic [15:0] nxt_cnt;
    logic        nxt_tick;
    logic [15:0] nxt_ticks;
    // decode helpers
    logic        wr_en;           // write taken this cycle
    logic        rd_setup;        // setup cycle of a transfer
    logic        restart;         // divisor write seen
    logic [15:0] divisor;         // effective n
    logic [5:0]  pre_top;         // prescale terminal value
    logic        sync_mode;
    logic        high_speed;
    logic        wide_div;

    // address decode used by the error flag on reads and writes
    // the tick count address is mapped but read only
    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = (a == OFS_DIV_LOW) || (a == OFS_DIV_HIGH) ||
                      (a == OFS_TX_STATUS) || (a == OFS_BAUD_CTRL) ||
                      (a == OFS_TICK_COUNT);
    endfunction

    // handshake: zero wait states, every access ends in its first
    // access cycle; the error flag only stands during the access phase
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_mapped(paddr_i);
    assign wr_en     = psel_i && penable_i && pwrite_i;
    assign rd_setup  = psel_i && !penable_i;

    // configuration selects
    // mode changes take effect without restarting the counter
    assign sync_mode  = tx_status_ff[SYNC_MODE_BIT];
    assign high_speed = tx_status_ff[HIGH_SPEED_BIT];
    assign wide_div   = baud_ctrl_ff[WIDE_DIV_BIT];

    // register next values
    // only the low byte of the write data is stored
    // writes to the tick count or unmapped addresses are dropped
    always_comb begin
        nxt_div_low   = div_low_ff;
        nxt_div_high  = div_high_ff;
        nxt_tx_status = tx_status_ff;
        nxt_baud_ctrl = baud_ctrl_ff;
        if (wr_en) begin
            case (paddr_i)
                OFS_DIV_LOW:   nxt_div_low   = pwdata_i[7:0];
                OFS_DIV_HIGH:  nxt_div_high  = pwdata_i[7:0];
                OFS_TX_STATUS: nxt_tx_status = pwdata_i[7:0];
                OFS_BAUD_CTRL: nxt_baud_ctrl = pwdata_i[7:0];
                default:       nxt_div_low   = div_low_ff;
            endcase
        end
    end

    // register storage
    // every control register clears to zero on reset
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            div_low_ff   <= DIV_LOW_RST;
            div_high_ff  <= DIV_HIGH_RST;
            tx_status_ff <= TX_STATUS_RST;
            baud_ctrl_ff <= BAUD_CTRL_RST;
        end else begin
            div_low_ff   <= nxt_div_low;
            div_high_ff  <= nxt_div_high;
            tx_status_ff <= nxt_tx_status;
            baud_ctrl_ff <= nxt_baud_ctrl;
        end
    end

    // read mux, selects the word of the addressed register
    always_comb begin
        rd_word = RDATA_RST;
        case (paddr_i)
            OFS_DIV_LOW:    rd_word = {24'h00_0000, div_low_ff};
            OFS_DIV_HIGH:   rd_word = {24'h00_0000, div_high_ff};
            OFS_TX_STATUS:  rd_word = {24'h00_0000, tx_status_ff};
            OFS_BAUD_CTRL:  rd_word = {24'h00_0000, baud_ctrl_ff};
            OFS_TICK_COUNT: rd_word = {16'h0000, ticks_ff};     // read only
            default:        rd_word = RDATA_RST;                // unmapped reads zero
        endcase
    end

    // read word taken at the end of the setup cycle, so the access
    // cycle sees a flip-flop output and still needs no wait state;
    // a tick count read shows the count as the setup cycle ended
    always_comb begin
        nxt_prdata = prdata_ff;             // hold through the access
        if (rd_setup) begin
            nxt_prdata = rd_word;           // capture on setup
        end
    end

    // read data storage
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prdata_ff <= RDATA_RST;
        end else begin
            prdata_ff <= nxt_prdata;
        end
    end

    // read data leaves straight from its flip-flop
    assign prdata_o = prdata_ff;

    // divisor write restarts counting
    // either divisor byte restarts prescaler and counter together
    assign restart = wr_en && ((paddr_i == OFS_DIV_HIGH) ||
                               (paddr_i == OFS_DIV_LOW));

    // effective divisor: high byte only in wide mode
    // narrow mode forces the upper byte to zero
    assign divisor = wide_div ? {div_high_ff, div_low_ff}
                              : {8'h00, div_low_ff};

    // prescale selection per mode
    // synchronous mode ignores the high speed select
    // terminal value is the prescale ratio minus one
    always_comb begin
        if (sync_mode) begin
            pre_top = PRE_DIV4;
        end else if (!high_speed) begin
            pre_top = wide_div ? PRE_DIV16 : PRE_DIV64;
        end else begin
            pre_top = wide_div ? PRE_DIV4 : PRE_DIV16;
        end
    end

    // counter next values: prescale then divisor count of n+1
    // restart wins over counting in the same cycle
    // the >= compares also end a count left above a smaller new top
    // after a mode change, so the chain never runs away
    always_comb begin
        nxt_pre   = pre_ff;
        nxt_cnt   = cnt_ff;
        nxt_tick  = 1'b0;
        nxt_ticks = ticks_ff;
        if (restart) begin
            nxt_pre = PRESCALE_RST;
            nxt_cnt = COUNT_RST;
        end else if (pre_ff >= pre_top) begin
            nxt_pre = PRESCALE_RST;
            if (cnt_ff >= divisor) begin
                nxt_cnt   = COUNT_RST;
                nxt_tick  = 1'b1;
                nxt_ticks = ticks_ff + 16'h0001;
            end else begin
                nxt_cnt = cnt_ff + 16'h0001;
            end
        end else begin
            nxt_pre = pre_ff + 6'h01;
        end
    end

    // counter storage
    // tick and tick count clear on reset
    // no tick is issued while reset is held
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pre_ff   <= PRESCALE_RST;
            cnt_ff   <= COUNT_RST;
            tick_ff  <= 1'b0;
            ticks_ff <= COUNT_RST;
        end else begin
            pre_ff   <= nxt_pre;
            cnt_ff   <= nxt_cnt;
            tick_ff  <= nxt_tick;
            ticks_ff <= nxt_ticks;
        end
    end

    // tick leaves straight from its flip-flop
    // one clock wide, once per bit period
    assign bit_tick_o = tick_ff;

endmodule

/* core/rate_gen_pkg.sv */
// package with register map, field positions and reset values of the rate generator
package rate_gen_pkg;
    // register byte addresses on the apb bus
    localparam logic [11:0] OFS_DIV_LOW    = 12'h000;
    localparam logic [11:0] OFS_DIV_HIGH   = 12'h004;
    localparam logic [11:0] OFS_TX_STATUS  = 12'h008;
    localparam logic [11:0] OFS_BAUD_CTRL  = 12'h00C;
    localparam logic [11:0] OFS_TICK_COUNT = 12'h010;
    // field positions
    localparam int SYNC_MODE_BIT   = 4;  // transmit_status_control
    localparam int HIGH_SPEED_BIT  = 2;  // transmit_status_control
    localparam int WIDE_DIV_BIT    = 3;  // baud_control
    // reset values
    localparam logic [7:0]  DIV_LOW_RST    = 8'h00;
    localparam logic [7:0]  DIV_HIGH_RST   = 8'h00;
    localparam logic [7:0]  TX_STATUS_RST  = 8'h00;
    localparam logic [7:0]  BAUD_CTRL_RST  = 8'h00;
    localparam logic [15:0] COUNT_RST      = 16'h0000;
    localparam logic [31:0] RDATA_RST      = 32'h0000_0000;
    localparam logic [5:0]  PRESCALE_RST   = 6'h00;
    // prescale terminal values: divide by 64, 16, 4
    localparam logic [5:0]  PRE_DIV64      = 6'h3F;
    localparam logic [5:0]  PRE_DIV16      = 6'h0F;
    localparam logic [5:0]  PRE_DIV4       = 6'h03;
endpackage

/* testbench/rate_gen_props.sv */
// checker of bus and bit tick behaviour of the rate generator
`timescale 1ns/10ps
module rate_gen_props
    import rate_gen_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        bit_tick_o
);
    logic [7:0]  lo_ff, hi_ff, tx_ff, bc_ff; // shadow registers
    logic [23:0] gap_ff;                     // cycles since last tick
    logic        seen_ff;                    // gap valid, no write since
    wire         acc = psel_i && penable_i;
    wire         wr  = acc && pwrite_i;
    wire         bad = paddr_i > OFS_TICK_COUNT || paddr_i[1:0] != 2'h0;
    wire         wd  = bc_ff[WIDE_DIV_BIT];
    wire         hs  = tx_ff[HIGH_SPEED_BIT];
    wire  [15:0] n   = wd ? {hi_ff, lo_ff} : {8'h00, lo_ff};
    wire  [23:0] p   = tx_ff[SYNC_MODE_BIT] ? 24'h00_0004 : (wd ^ hs) ? 24'h00_0010
                       : wd ? 24'h00_0004 : 24'h00_0040;
    wire  [23:0] per = p * (24'(n) + 24'h00_0001);
    // shadow the control writes and time the ticks
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            {lo_ff, hi_ff, tx_ff, bc_ff, gap_ff, seen_ff} <= '0;
        end else begin
            gap_ff <= bit_tick_o ? 24'h00_0001 : gap_ff + 24'h00_0001;
            seen_ff <= !wr && (seen_ff || bit_tick_o);
            if (wr && paddr_i == OFS_DIV_LOW) lo_ff <= pwdata_i[7:0];
            if (wr && paddr_i == OFS_DIV_HIGH) hi_ff <= pwdata_i[7:0];
            if (wr && paddr_i == OFS_TX_STATUS) tx_ff <= pwdata_i[7:0];
            if (wr && paddr_i == OFS_BAUD_CTRL) bc_ff <= pwdata_i[7:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    sequence s_divwr; wr && (paddr_i == OFS_DIV_LOW || paddr_i == OFS_DIV_HIGH); endsequence
    property p_ready; acc |-> pready_o; endproperty
    a_ready: assert property (p_ready) else $error("ready low");
    property p_err; acc && bad |-> pslverr_o; endproperty
    a_err: assert property (p_err) else $error("no error on unmapped");
    property p_noerr; acc && !bad |-> !pslverr_o; endproperty
    a_noerr: assert property (p_noerr) else $error("error on mapped");
    property p_pulse; bit_tick_o |=> !bit_tick_o; endproperty
    a_pulse: assert property (p_pulse) else $error("tick too long");
    property p_restart; s_divwr |=> !bit_tick_o [*4]; endproperty
    a_restart: assert property (p_restart) else $error("no restart");
    property p_period; bit_tick_o && seen_ff |-> gap_ff == per; endproperty
    a_period: assert property (p_period) else $error("bad period");
    property p_rdhi;
        acc && !pwrite_i && paddr_i == OFS_DIV_HIGH |-> prdata_o == 32'(hi_ff);
    endproperty
    a_rdhi: assert property (p_rdhi) else $error("high byte");
    property p_rdlo;
        acc && !pwrite_i && paddr_i == OFS_DIV_LOW |-> prdata_o == 32'(lo_ff);
    endproperty
    a_rdlo: assert property (p_rdlo) else $error("low byte");
endmodule

/* testbench/shift_model.sv */
// tick consumer in place of the shift logic, latches tick spacing
`timescale 1ns/10ps
module shift_model (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        bit_tick_i,
    output logic      [23:0] gap_o
);
    logic [23:0] cnt_ff; // cycles since last tick
    // count cycles and latch the count at each tick
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            {gap_o, cnt_ff} <= '0;
        end else begin
            cnt_ff <= bit_tick_i ? 24'h00_0001 : cnt_ff + 24'h00_0001;
            if (bit_tick_i) gap_o <= cnt_ff;
        end
    end
endmodule

/* testbench/testbench.sv */
// bench for the rate generator: register access and tick spacing
`timescale 1ns/10ps
module testbench;
    import rate_gen_pkg::*;
    logic        clk_i, srst_i, psel, penable, pwrite, pready, pslverr, tick, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [23:0] gap, per;
    int          bad_count, checks, cyc, ntick;
    uart_baud_rate_generator u_dut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .bit_tick_o(tick));
    shift_model u_far (.clk_i(clk_i), .srst_i(srst_i), .bit_tick_i(tick), .gap_o(gap));
    // reference count of ticks for the tick count register
    always @(posedge tick) ntick++;
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            stop_test;
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        srst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        srst_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            chk(rd, 32'h0000_0000);
        end
        apb(1'b0, 12'h014, 32'h0);
        chk(32'({err, rd[0]}), 32'h0000_0002);
        apb(1'b1, OFS_DIV_HIGH, 32'h0000_0001);
        apb(1'b0, OFS_DIV_HIGH, 32'h0);
        chk(rd, 32'h0000_0001);
        $display("test registers done");
        for (int m = 0; m < 8; m++) begin
            apb(1'b1, OFS_TX_STATUS, 32'((m >> 2) << SYNC_MODE_BIT | (m & 1) << HIGH_SPEED_BIT));
            apb(1'b1, OFS_BAUD_CTRL, 32'(((m >> 1) & 1) << WIDE_DIV_BIT));
            apb(1'b1, OFS_DIV_LOW, 32'h0000_0002);
            per = m[2] ? 24'd4 : (m[1] ^ m[0]) ? 24'd16 : m[1] ? 24'd4 : 24'd64;
            per = per * (m[1] ? 24'd259 : 24'd3);
            repeat (2) @(posedge tick);
            @(posedge clk_i);
            #1;
            chk(32'(gap), 32'(per));
        end
        $display("test modes done");
        apb(1'b0, OFS_TICK_COUNT, 32'h0);
        chk(rd, 32'(ntick[15:0]));
        apb(1'b1, OFS_TICK_COUNT, 32'h0000_FFFF);
        chk(32'(err), 32'h0000_0000);
        apb(1'b0, OFS_TICK_COUNT, 32'h0);
        chk(rd, 32'(ntick[15:0]));
        $display("test tick count done");
        stop_test;
    end
endmodule
bind uart_baud_rate_generator rate_gen_props u_props (.clk_i(clk_i), .srst_i(srst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .bit_tick_o(bit_tick_o));
